// *** tcw_core.sv ***
// Timer/counter core: counter, commands, event actions, compare channels
// Assumes configuration ports come from same-clock logic; event_in is from the clock domain too
`timescale 1ns/1ps
`include "tcw_regs.svh"
module tcw_core #(
   parameter int CH = 2,
   parameter int W  = 32
) (
   input  wire logic                clk_in,
   input  wire logic                rst_n_in,
   input  wire logic                enable_in,
   input  wire logic                odd_instance_in,
   input  wire logic [1:0]          width_select_in,
   input  wire logic [1:0]          waveform_select_in,
   input  wire logic                direction_bit_in,
   input  wire logic                single_run_enable_in,
   input  wire logic [1:0]          command_field_in,
   input  wire logic                command_valid_in,
   input  wire logic [1:0]          event_action_select_in,
   input  wire logic                event_in,
   input  wire logic                prescale_tick_in,
   input  wire logic                wrap_event_out_enable_in,
   input  wire logic [CH-1:0]       channel_match_irq_enable_in,
   input  wire logic [CH-1:0]       channel_match_event_enable_in,
   input  wire logic [CH-1:0]       output_invert_bit_in,
   input  wire logic [7:0]          period_reg_in,
   input  wire logic [CH*W-1:0]     channel_compare_value_in,
   input  wire logic                count_write_in,
   input  wire logic [W-1:0]        count_wdata_in,
   input  wire logic                wrap_flag_clear_in,
   input  wire logic [CH-1:0]       match_flag_clear_in,
   output logic [W-1:0]             count_out,
   output logic                     wrap_flag_out,
   output logic [CH-1:0]            channel_match_flag_out,
   output logic                     irq_out,
   output logic                     wrap_event_out,
   output logic [CH-1:0]            match_event_out,
   output logic                     stopped_out,
   output logic                     subordinate_out,
   output logic [CH-1:0]            waveform_output_out
);
   tcw_wave_if #(.CH(CH), .W(W)) wif ();

   tcw_pkg::tcw_state_t state_q, state_d;
   logic [W-1:0]  cnt_q, cnt_d;
   logic          wflag_q, wflag_d;
   logic [CH-1:0] mflag_q, mflag_d;
   logic [CH-1:0] mpend_q, mpend_d;
   logic          irq_q, irq_d;
   logic          wev_q, wev_d;
   logic [CH-1:0] mev_q, mev_d;
   logic          sub_q, sub_d;
   logic [CH-1:0] wo_q;
   logic          start_s, stop_s;

   logic          subord;
   logic [W-1:0]  mask;
   logic [W-1:0]  top;
   logic [W-1:0]  cval [CH];
   logic          retrig, tick, running, at_top, at_zero, wrap;
   logic [CH-1:0] match;

   // Unpack per-channel compare values
   generate
      for (genvar g = 0; g < CH; g++) begin : g_cv
         assign cval[g] = channel_compare_value_in[g*W +: W];
      end
   endgenerate

   // Width mask and ceiling select
   always_comb begin
      subord = odd_instance_in && (width_select_in == `TCW_WIDTH_WORD);
      case (width_select_in)
         `TCW_WIDTH_BYTE: mask = W'(32'h0000_00FF);
         `TCW_WIDTH_WORD: mask = W'(32'hFFFF_FFFF);
         default:         mask = W'(32'h0000_FFFF);
      endcase
      if (waveform_select_in == `TCW_WAVE_COMPARE_FREQUENCY_MODE || waveform_select_in == `TCW_WAVE_COMPARE_PULSE_MODE) begin
         top = cval[0] & mask;
      end else if (width_select_in == `TCW_WIDTH_BYTE) begin
         top = W'(period_reg_in);
      end else begin
         top = mask;
      end
   end

   // Tick stream, commands and match detection
   always_comb begin
      running = (state_q == tcw_pkg::TCW_ST_RUN);
      retrig  = (command_valid_in && command_field_in == `TCW_CMD_RETRIGGER) ||
                (event_in && event_action_select_in == `TCW_EVACT_RETRIG);
      // Event counting uses raw events, prescaler ticks otherwise
      if (event_action_select_in == `TCW_EVACT_COUNT) tick = event_in;
      else tick = prescale_tick_in;
      at_top  = (cnt_q == top);
      at_zero = (cnt_q == '0);
      wrap    = tick && running && (direction_bit_in ? at_zero : at_top);
      for (int i = 0; i < CH; i++) begin
         match[i] = (cnt_q == (cval[i] & mask));
      end
   end

   // Counter state machine
   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      start_s = 1'b0;
      stop_s  = 1'b0;
      case (state_q)
         tcw_pkg::TCW_ST_IDLE: begin
            // Re-trigger and start actions wait for the first event or a retrigger command
            if (enable_in && !subord && ((event_action_select_in != `TCW_EVACT_RETRIG &&
                event_action_select_in != `TCW_EVACT_START) || retrig ||
                (event_in && event_action_select_in == `TCW_EVACT_START))) begin
               state_d = tcw_pkg::TCW_ST_RUN;
               start_s = 1'b1;
               if (cnt_q == '0 && direction_bit_in) cnt_d = top;
            end
         end
         tcw_pkg::TCW_ST_RUN: begin
            if (!enable_in || subord) begin
               state_d = tcw_pkg::TCW_ST_IDLE;
               stop_s  = 1'b1;
            end else if (command_valid_in && command_field_in == `TCW_CMD_STOP) begin
               state_d = tcw_pkg::TCW_ST_STOP;
               stop_s  = 1'b1;
            end else if (retrig) begin
               cnt_d = direction_bit_in ? top : '0;
            end else if (wrap) begin
               cnt_d = direction_bit_in ? top : '0;
               if (single_run_enable_in) begin
                  state_d = tcw_pkg::TCW_ST_STOP;
                  stop_s  = 1'b1;
               end
            end else if (tick) begin
               cnt_d = direction_bit_in ? ((cnt_q - W'(1)) & mask) : ((cnt_q + W'(1)) & mask);
            end
         end
         tcw_pkg::TCW_ST_STOP: begin
            // Start events act here and in idle, never while running
            if (!enable_in || subord) begin
               state_d = tcw_pkg::TCW_ST_IDLE;
            end else if (retrig || (event_in && event_action_select_in == `TCW_EVACT_START)) begin
               state_d = tcw_pkg::TCW_ST_RUN;
               start_s = 1'b1;
            end
         end
         default: state_d = tcw_pkg::TCW_ST_IDLE;
      endcase
      // Software write beats count, clear and reload; ignored on a subordinate
      if (count_write_in && !subord) cnt_d = count_wdata_in & mask;
   end

   // Flags and events; hardware set beats software clear
   always_comb begin
      sub_d   = subord;
      mpend_d = running ? match : '0;
      wflag_d = (wflag_q && !wrap_flag_clear_in) || wrap;
      wev_d   = wrap && wrap_event_out_enable_in;
      for (int i = 0; i < CH; i++) begin
         // A match is flagged on the tick after it is seen
         mflag_d[i] = (mflag_q[i] && !match_flag_clear_in[i]) || (mpend_q[i] && tick);
         mev_d[i]   = mpend_q[i] && tick && channel_match_event_enable_in[i];
      end
      irq_d = wflag_d || |(mflag_d & channel_match_irq_enable_in);
   end

   // Register core state
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_q <= tcw_pkg::TCW_ST_IDLE;
         cnt_q   <= '0;
         wflag_q <= 1'b0;
         mflag_q <= '0;
         mpend_q <= '0;
         irq_q   <= 1'b0;
         wev_q   <= 1'b0;
         mev_q   <= '0;
         sub_q   <= 1'b0;
         wo_q    <= '0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         wflag_q <= wflag_d;
         mflag_q <= mflag_d;
         mpend_q <= mpend_d;
         irq_q   <= irq_d;
         wev_q   <= wev_d;
         mev_q   <= mev_d;
         sub_q   <= sub_d;
         wo_q    <= wif.wave_out;
      end
   end

   // Feed the waveform unit
   assign wif.tick    = tick;
   assign wif.running = running;
   assign wif.down    = direction_bit_in;
   assign wif.start   = start_s;
   assign wif.stop    = stop_s;
   assign wif.wrap    = wrap;
   assign wif.at_top  = at_top;
   assign wif.at_zero = at_zero;
   assign wif.wave    = tcw_pkg::tcw_wave_t'(waveform_select_in);
   assign wif.match   = match & {CH{running}};
   assign wif.invert  = output_invert_bit_in;

   tcw_wave_gen #(.CH(CH)) u_wave (
      .clk_in   (clk_in),
      .rst_n_in (rst_n_in),
      .wif      (wif)
   );

   // Outputs straight from flip-flops
   assign count_out              = cnt_q;
   assign wrap_flag_out          = wflag_q;
   assign channel_match_flag_out = mflag_q;
   assign irq_out                = irq_q;
   assign wrap_event_out         = wev_q;
   assign match_event_out        = mev_q;
   assign stopped_out            = state_q[2]; // One-hot stop bit, no decode logic
   assign subordinate_out        = sub_q;
   assign waveform_output_out    = wo_q;
endmodule

// *** tcw_core_assertions.sv ***
// Concurrent checks on the timer/counter core
// Bound to tcw_core; sees only its top-level ports, one clock domain
`timescale 1ns/1ps
module tcw_core_assertions #(
   parameter int CH = 2,
   parameter int W  = 32
) (
   input wire logic          clk_in,
   input wire logic          rst_n_in,
   input wire logic          enable_in,
   input wire logic          odd_instance_in,
   input wire logic [1:0]    width_select_in,
   input wire logic [1:0]    waveform_select_in,
   input wire logic          direction_bit_in,
   input wire logic          single_run_enable_in,
   input wire logic [1:0]    command_field_in,
   input wire logic          command_valid_in,
   input wire logic [1:0]    event_action_select_in,
   input wire logic          event_in,
   input wire logic          prescale_tick_in,
   input wire logic          wrap_event_out_enable_in,
   input wire logic [CH-1:0] output_invert_bit_in,
   input wire logic [7:0]    period_reg_in,
   input wire logic          count_write_in,
   input wire logic [W-1:0]  count_wdata_in,
   input wire logic [W-1:0]  count_out,
   input wire logic          wrap_flag_out,
   input wire logic          wrap_event_out,
   input wire logic          stopped_out,
   input wire logic          subordinate_out,
   input wire logic [CH-1:0] waveform_output_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   // Running 8-bit plain-mode counter seeing a lone prescaler tick
   sequence s_run8;
      enable_in && $past(enable_in) && !stopped_out && width_select_in == 2'h1 && !waveform_select_in[0]
      && event_action_select_in == 2'h0 && prescale_tick_in && !event_in && !count_write_in && !command_valid_in;
   endsequence
   // Stop while running with nothing else competing
   sequence s_stop;
      enable_in && $past(enable_in) && !stopped_out && event_action_select_in == 2'h0 && command_valid_in
      && command_field_in == 2'h2 && !prescale_tick_in && !count_write_in && output_invert_bit_in == '0;
   endsequence

   a_wrap_up: assert property (
      s_run8 ##0 (!direction_bit_in && count_out == W'(period_reg_in)) |=> count_out == '0 && wrap_flag_out)
      else $error("up count did not wrap to zero");
   a_wrap_down: assert property (
      s_run8 ##0 (direction_bit_in && count_out == '0) |=> count_out == W'($past(period_reg_in)))
      else $error("down count did not reload ceiling");
   a_write_wins: assert property (
      count_write_in && !subordinate_out && !odd_instance_in |=> count_out == $past(count_wdata_in))
      else $error("counter write lost");
   a_stop_clears: assert property (
      s_stop |=> stopped_out && $stable(count_out) ##1 waveform_output_out == '0)
      else $error("stop did not hold count and clear outputs");
   a_stop_holds: assert property (
      stopped_out && !count_write_in && !command_valid_in && !event_in |=> $stable(count_out))
      else $error("stopped counter moved");
   a_sub_flag: assert property (
      (odd_instance_in && width_select_in == 2'h2) [*3] |-> subordinate_out)
      else $error("subordinate flag missing");
   a_sub_ignores: assert property (
      subordinate_out && count_write_in |=> $stable(count_out))
      else $error("subordinate write changed count");
   a_wrap_event: assert property (
      wrap_event_out |-> wrap_flag_out && $past(wrap_event_out_enable_in))
      else $error("wrap event without flag or enable");
   a_single_halt: assert property (
      $rose(wrap_flag_out) && single_run_enable_in |-> ##[0:2] stopped_out)
      else $error("single run did not halt");
endmodule

bind tcw_core tcw_core_assertions #(.CH(CH), .W(W)) i_chk (.clk_in, .rst_n_in, .enable_in, .odd_instance_in,
   .width_select_in, .waveform_select_in, .direction_bit_in, .single_run_enable_in, .command_field_in,
   .command_valid_in, .event_action_select_in, .event_in, .prescale_tick_in, .wrap_event_out_enable_in,
   .output_invert_bit_in, .period_reg_in, .count_write_in, .count_wdata_in, .count_out, .wrap_flag_out,
   .wrap_event_out, .stopped_out, .subordinate_out, .waveform_output_out);

// *** tcw_pkg.sv ***
// Types for the timer/counter compare and waveform core
// Assumes tcw_regs.svh is on the include path
`include "tcw_regs.svh"
package tcw_pkg;
   typedef enum logic [1:0] {
      TCW_HALF = 2'h0,
      TCW_BYTE = 2'h1,
      TCW_WORD = 2'h2
   } tcw_width_t;
   typedef enum logic [1:0] {
      TCW_PLAIN_FREQUENCY_MODE = 2'h0,
      TCW_COMPARE_FREQUENCY_MODE = 2'h1,
      TCW_PLAIN_PULSE_MODE = 2'h2,
      TCW_COMPARE_PULSE_MODE = 2'h3
   } tcw_wave_t;
   typedef enum logic [2:0] {
      TCW_ST_IDLE = 3'h1,
      TCW_ST_RUN  = 3'h2,
      TCW_ST_STOP = 3'h4
   } tcw_state_t;
endpackage

// *** tcw_regs.svh ***
// Constants for the timer/counter compare and waveform core
// Included by the package and tcw_core; guarded against double inclusion
`ifndef TCW_REGS_SVH
`define TCW_REGS_SVH
`define TCW_WIDTH_BYTE     2'h1
`define TCW_WIDTH_HALF     2'h0
`define TCW_WIDTH_WORD     2'h2
`define TCW_WIDTH_RESET    2'h0
`define TCW_CMD_NONE       2'h0
`define TCW_CMD_RETRIGGER  2'h1
`define TCW_CMD_STOP       2'h2
`define TCW_EVACT_OFF      2'h0
`define TCW_EVACT_RETRIG   2'h1
`define TCW_EVACT_COUNT    2'h2
`define TCW_EVACT_START    2'h3
`define TCW_WAVE_PLAIN_FREQUENCY_MODE      2'h0
`define TCW_WAVE_COMPARE_FREQUENCY_MODE      2'h1
`define TCW_WAVE_PLAIN_PULSE_MODE      2'h2
`define TCW_WAVE_COMPARE_PULSE_MODE      2'h3
`define TCW_PERIOD_RESET   8'hFF
`endif

// *** tcw_tick_src.sv ***
// Far-side tick source: prescaler ticks into the core, one-cycle pulses
// Assumes the bench gates it with run_in on the core clock
`timescale 1ns/1ps
module tcw_tick_src #(
   parameter int DIV = 3
) (
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   input  wire logic        run_in,
   output logic             tick_out,
   output logic [15:0]      tick_cnt_out
);
   logic [7:0] div_q;

   // Divider; the tally lets the bench stop after an exact number of ticks
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         div_q <= 8'h00;
         tick_out <= 1'b0;
         tick_cnt_out <= 16'h0000;
      end else begin
         tick_out <= 1'b0;
         div_q <= (run_in && div_q != 8'(DIV - 1)) ? div_q + 8'h01 : 8'h00;
         if (run_in && div_q == 8'(DIV - 1)) begin
            tick_out <= 1'b1;
            tick_cnt_out <= tick_cnt_out + 16'h0001;
         end
      end
   end
endmodule

// *** tcw_wave_gen.sv ***
// Waveform generator for the compare channels
// Assumes strobes in the interface are single-cycle and on the core clock
`timescale 1ns/1ps
module tcw_wave_gen #(
   parameter int CH = 2
) (
   input  wire logic  clk_in,
   input  wire logic  rst_n_in,
   tcw_wave_if.gen    wif
);
   logic [CH-1:0] raw_q;
   logic [CH-1:0] raw_d;
   logic          pulse_q;
   logic          pulse_d;

   // Next raw waveform per channel, before inversion
   always_comb begin
      raw_d   = raw_q;
      pulse_d = 1'b0;
      if (wif.stop) begin
         raw_d = '0;
      end else if (wif.start) begin
         // Plain pulse start level depends on direction; other modes start low
         for (int i = 0; i < CH; i++) begin
            raw_d[i] = (wif.wave == tcw_pkg::TCW_PLAIN_PULSE_MODE) ? ~wif.down : 1'b0;
         end
      end else if (wif.tick && wif.running) begin
         case (wif.wave)
            tcw_pkg::TCW_PLAIN_FREQUENCY_MODE: begin
               raw_d = raw_q ^ wif.match;
            end
            tcw_pkg::TCW_COMPARE_FREQUENCY_MODE: begin
               raw_d[0] = raw_q[0] ^ wif.wrap;
               for (int i = 1; i < CH; i++) begin
                  raw_d[i] = raw_q[i] ^ wif.match[i];
               end
            end
            tcw_pkg::TCW_PLAIN_PULSE_MODE: begin
               for (int i = 0; i < CH; i++) begin
                  if (!wif.down) begin
                     // Match clear wins when match and ceiling hit together
                     if (wif.match[i]) raw_d[i] = 1'b0;
                     else if (wif.at_top) raw_d[i] = 1'b1;
                  end else begin
                     if (wif.match[i]) raw_d[i] = 1'b1;
                     else if (wif.at_zero) raw_d[i] = 1'b0;
                  end
               end
            end
            tcw_pkg::TCW_COMPARE_PULSE_MODE: begin
               pulse_d = wif.wrap;
               for (int i = 1; i < CH; i++) begin
                  if (wif.wrap) raw_d[i] = ~wif.down;
                  else if (wif.match[i]) raw_d[i] = wif.down;
               end
            end
            default: raw_d = raw_q;
         endcase
      end
   end

   // Register the waveform state
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         raw_q   <= '0;
         pulse_q <= 1'b0;
      end else begin
         raw_q   <= raw_d;
         pulse_q <= pulse_d;
      end
   end

   // Inversion applied last so it mirrors every action; COMPARE_PULSE_MODE output 0 is a low pulse
   generate
      for (genvar g = 0; g < CH; g++) begin : g_out
         if (g == 0) begin : g_ch0
            assign wif.wave_out[g] = ((wif.wave == tcw_pkg::TCW_COMPARE_PULSE_MODE) ? (wif.running & ~pulse_q) : raw_q[g])
                                     ^ wif.invert[g];
         end else begin : g_chn
            assign wif.wave_out[g] = raw_q[g] ^ wif.invert[g];
         end
      end
   endgenerate
endmodule

// *** tcw_wave_if.sv ***
// Interface carrying counter state from the core to the waveform unit
// Both ends run on the one core clock
`timescale 1ns/1ps
interface tcw_wave_if #(parameter int CH = 2, parameter int W = 32);
   logic                 tick;
   logic                 running;
   logic                 down;
   logic                 start;
   logic                 stop;
   logic                 wrap;
   logic                 at_top;
   logic                 at_zero;
   tcw_pkg::tcw_wave_t   wave;
   logic [CH-1:0]        match;
   logic [CH-1:0]        invert;
   logic [CH-1:0]        wave_out;
   modport core (output tick, running, down, start, stop, wrap, at_top, at_zero, wave, match, invert,
                 input wave_out);
   modport gen  (input tick, running, down, start, stop, wrap, at_top, at_zero, wave, match, invert,
                 output wave_out);
endinterface

// *** timer_counter_compare_waveform_core_tb_top.sv ***
// Self-checking bench for the timer/counter core, 8-bit width (word width in the subordinate test), period 5
// Assumes the tick source model drives the prescaler input
`timescale 1ns/1ps
module timer_counter_compare_waveform_core_tb_top;
   typedef struct packed {logic dir; logic [1:0] wave; logic [7:0] start, n, cnt; logic flag;} tcw_row_t;
   logic        clk = 1'b0, rst_n = 1'b0, en = 1'b0, odd = 1'b0, dir = 1'b0, one = 1'b0, run = 1'b0;
   logic        cmdv = 1'b0, evt = 1'b0, cw = 1'b0, wfc = 1'b0, tick, wflag, irq, wev, stp, sub;
   logic [1:0]  wsel = 2'h1, wave = 2'h0, cmd = 2'h0, act = 2'h0, mfc = 2'h0, mflag, mev, wo;
   logic [1:0]  inv = 2'h0;
   int          wev_n = 0;
   logic [63:0] ccv = 64'h0000000000000005;
   logic [31:0] cwd = 32'h00000000, cnt;
   logic [15:0] tcnt;
   int          failures = 0, checks = 0;
   // Ceiling 5 in every mode: compare modes take channel 0, which is 5 here
   tcw_row_t    rows [5] = '{'{1'b0, 2'h1, 8'h03, 8'h02, 8'h05, 1'b0}, '{1'b0, 2'h0, 8'h05, 8'h01, 8'h00, 1'b1},
                             '{1'b1, 2'h2, 8'h00, 8'h01, 8'h05, 1'b1}, '{1'b1, 2'h3, 8'h04, 8'h03, 8'h01, 1'b0},
                             '{1'b0, 2'h0, 8'h04, 8'h03, 8'h01, 1'b1}};

   tcw_core i_dut (.clk_in(clk), .rst_n_in(rst_n), .enable_in(en), .odd_instance_in(odd), .width_select_in(wsel),
      .waveform_select_in(wave), .direction_bit_in(dir), .single_run_enable_in(one), .command_field_in(cmd),
      .command_valid_in(cmdv), .event_action_select_in(act), .event_in(evt), .prescale_tick_in(tick),
      .wrap_event_out_enable_in(1'b1), .channel_match_irq_enable_in(2'h3), .channel_match_event_enable_in(2'h3),
      .output_invert_bit_in(inv), .period_reg_in(8'h05), .channel_compare_value_in(ccv), .count_write_in(cw),
      .count_wdata_in(cwd), .wrap_flag_clear_in(wfc), .match_flag_clear_in(mfc), .count_out(cnt),
      .wrap_flag_out(wflag), .channel_match_flag_out(mflag), .irq_out(irq), .wrap_event_out(wev),
      .match_event_out(mev), .stopped_out(stp), .subordinate_out(sub), .waveform_output_out(wo));
   tcw_tick_src #(.DIV(3)) i_src (.clk_in(clk), .rst_n_in(rst_n), .run_in(run), .tick_out(tick),
      .tick_cnt_out(tcnt));

   // Free-running 50 MHz clock
   initial begin
      forever #10 clk = ~clk;
   end

   // Tally wrap events; each is a one-cycle pulse, so count them as they pass
   always @(posedge clk) begin
      if (wev === 1'b1) wev_n <= wev_n + 1;
   end

   task automatic step(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic chk_count(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic chk_flag(input logic got, input logic exp);
      chk_count({31'h0, got}, {31'h0, exp});
   endtask
   // Let exactly n prescaler ticks through, then let the core settle
   task automatic ticks(input int n);
      logic [15:0] base;
      base = tcnt;
      run <= 1'b1;
      for (int i = 0; i < 200 && tcnt != base + 16'(n); i++) @(posedge clk);
      run <= 1'b0;
      step(3);
   endtask
   task automatic command(input logic [1:0] c);
      cmd <= c;
      cmdv <= 1'b1;
      step(1);
      cmdv <= 1'b0;
      step(3);
   endtask
   task automatic pulse_event;
      evt <= 1'b1;
      step(1);
      evt <= 1'b0;
      step(3);
   endtask
   task automatic write_count(input logic [31:0] v);
      cwd <= v;
      cw <= 1'b1;
      step(1);
      cw <= 1'b0;
      step(2);
   endtask
   // Action select is only changed while disabled
   task automatic setup(input logic [1:0] a);
      en <= 1'b0;
      step(1);
      act <= a;
      en <= 1'b1;
      step(2);
   endtask
   task automatic print_verdict;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Guard against a hang; the run needs well under a thousand cycles
   initial begin
      #100000;
      failures++;
      print_verdict();
   end

   // Table of wrap cases, then the command and event-action cases
   initial begin
      step(5);
      rst_n <= 1'b1;
      en <= 1'b1;
      step(2);
      for (int i = 0; i < 5; i++) begin
         dir <= rows[i].dir;
         wave <= rows[i].wave;
         wfc <= 1'b1;
         step(1);
         wfc <= 1'b0;
         write_count({24'h0, rows[i].start});
         ticks(int'(rows[i].n));
         chk_count(cnt, {24'h0, rows[i].cnt});
         chk_flag(wflag, rows[i].flag);
         $display("test row %0d done", i);
      end
      command(2'h2);
      chk_flag(stp, 1'b1);
      ticks(2);
      chk_count(cnt, 32'h00000001);
      chk_count({30'h0, wo}, 32'h00000000);
      command(2'h1);
      chk_flag(stp, 1'b0);
      ticks(2);
      chk_count(cnt, 32'h00000003);
      command(2'h1);
      chk_count(cnt, 32'h00000000);
      $display("test stop and retrigger done");
      setup(2'h2);
      pulse_event();
      pulse_event();
      chk_count(cnt, 32'h00000002);
      setup(2'h3);
      write_count(32'h00000000);
      ticks(2);
      chk_count(cnt, 32'h00000000);
      pulse_event();
      ticks(2);
      chk_count(cnt, 32'h00000002);
      pulse_event();
      chk_count(cnt, 32'h00000002);
      setup(2'h1);
      ticks(2);
      chk_count(cnt, 32'h00000002);
      pulse_event();
      ticks(2);
      chk_count(cnt, 32'h00000004);
      pulse_event();
      chk_count(cnt, 32'h00000000);
      $display("test event actions done");
      setup(2'h0);
      one <= 1'b1;
      wfc <= 1'b1;
      step(1);
      wfc <= 1'b0;
      write_count(32'h00000003);
      ticks(4);
      chk_count(cnt, 32'h00000000);
      chk_flag(stp, 1'b1);
      one <= 1'b0;
      ccv <= 64'h0000000000000002;
      mfc <= 2'h3;
      wfc <= 1'b1;
      step(1);
      mfc <= 2'h0;
      wfc <= 1'b0;
      command(2'h1);
      ticks(3);
      chk_flag(wo[0], 1'b1);
      chk_flag(mflag[0], 1'b1);
      chk_flag(irq, 1'b1);
      inv <= 2'h1;
      step(2);
      chk_flag(wo[0], 1'b0);
      inv <= 2'h0;
      step(2);
      $display("test single run and waveform done");
      // Plain pulse: cleared on channel 0 match at 2, set again at the ceiling
      wave <= 2'h2;
      command(2'h1);
      ticks(3);
      chk_flag(wo[0], 1'b0);
      ticks(3);
      chk_flag(wo[0], 1'b1);
      // Compare frequency: ceiling is channel 0 (2), output 0 toggles on the wrap
      wave <= 2'h1;
      ticks(3);
      chk_flag(wo[0], 1'b0);
      chk_count(cnt, 32'h00000000);
      $display("test waveform modes done");
      odd <= 1'b1;
      wsel <= 2'h2;
      step(4);
      chk_flag(sub, 1'b1);
      write_count(32'h00000009);
      chk_count(cnt, 32'h00000000);
      $display("test subordinate done");
      chk_count(32'(wev_n), 32'h00000006);
      print_verdict();
   end
endmodule
